// *** pkg/isb_pkg.sv ***
// constants, types and checksum helper for the i2c slave packet buffers
package isb_pkg;

  // ****************************************************
  // addressing and packets
  // ****************************************************
  localparam logic [6:0] ISB_DEF_ADDR = 7'h2a;
  localparam logic ISB_DIR_WRITE = 1'b0;
  localparam int ISB_PKT_MAX = 22;
  localparam int ISB_CODE_W = 6;
  localparam logic [15:0] ISB_CRC_INIT = 16'hffff;
  localparam logic [15:0] ISB_CRC_POLY = 16'h8408;
  localparam logic [7:0] ISB_MIN_PKT = 8'h04;

  // ****************************************************
  // timing
  // ****************************************************
  localparam longint ISB_CLK_HZ = 40000000;
  localparam longint ISB_KEY_HOLD_S = 4;
  localparam int unsigned ISB_KEY_HOLD_CYC =
    32'(ISB_KEY_HOLD_S * ISB_CLK_HZ);

  // ****************************************************
  // byte engine states
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ACK_A   = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_ACK_W   = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_ACK_R   = 3'b110,
    ST_IGNORE  = 3'b111
  } isb_state_e;

  // end-of-write report to the foreground
  typedef struct packed {
    logic crc_ok;
    logic [7:0] cmd_type;
    logic [7:0] nbytes;
  } isb_done_s;

  // one byte step of the reflected 16-bit checksum
  function automatic logic [15:0] isb_crc_step(input logic [15:0] c,
                                               input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ ISB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// *** verilog/isb_i2c_slave.sv ***
// i2c slave with command write buffer and response read buffer
`timescale 1ns/10ps
module isb_i2c_slave #(
  parameter int WR_DEPTH = isb_pkg::ISB_PKT_MAX,
  parameter int RD_DEPTH = isb_pkg::ISB_PKT_MAX,
  parameter int unsigned KEY_HOLD_CYC = isb_pkg::ISB_KEY_HOLD_CYC
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // i2c pins; scl clocks the link-side shifter
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // command stream to foreground
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [7:0] cmd_data,
  output logic cmd_done,
  output isb_pkg::isb_done_s cmd_info,
  // response fill from foreground
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_type_err,
  // address control and nonvolatile store
  input wire logic addr_set,
  input wire logic [6:0] addr_set_val,
  input wire logic boot_valid,
  input wire logic [6:0] boot_addr,
  input wire logic boot_store,
  output logic nv_wr,
  output logic [6:0] nv_addr,
  // keys and address display
  input wire logic key_up,
  input wire logic key_dn,
  output logic show_addr,
  output logic [6:0] show_addr_val
);

  localparam int WAW = $clog2(WR_DEPTH);
  localparam int RAW = $clog2(RD_DEPTH);
  localparam logic [WAW:0] WFULL = (WAW+1)'(WR_DEPTH);
  localparam logic [WAW-1:0] WLAST = WAW'(WR_DEPTH - 1);

  // ****************************************************
  // link domain: byte shifter on scl rise
  // ****************************************************
  // held stable for a whole scl low phase after the 8th rise, so the
  // system side reads it only after seeing that rise through its sync
  logic [7:0] lnk_sh_q;

  always_ff @(posedge scl_clk) begin
    lnk_sh_q <= {lnk_sh_q[6:0], sda_i};
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [3:0] pin_m_q, pin_s_q;
  logic scl_p_q, sda_p_q;
  logic scl_s, sda_s, up_s, dn_s;
  logic rise_e, fall_e, start_e, stop_e;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      // keys idle low, link pins idle high: no false edge after reset
      pin_m_q <= 4'h3;
      pin_s_q <= 4'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      pin_m_q <= {key_dn, key_up, sda_i, scl_clk};
      pin_s_q <= pin_m_q;
      scl_p_q <= pin_s_q[0];
      sda_p_q <= pin_s_q[1];
    end
  end

  assign scl_s = pin_s_q[0];
  assign sda_s = pin_s_q[1];
  assign up_s = pin_s_q[2];
  assign dn_s = pin_s_q[3];
  // no bus timeout anywhere: a stopped scl just holds the state
  assign rise_e = scl_s & ~scl_p_q;
  assign fall_e = ~scl_s & scl_p_q;
  assign start_e = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_e = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************************
  // byte engine, buffers, address
  // ****************************************************
  isb_pkg::isb_state_e st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic rw_q, rw_d, ack_q, ack_d, lock_q, lock_d, oe_q, oe_d;
  logic [6:0] addr_q, addr_d;
  logic boot_ld_q, boot_ld_d, nv_wr_q, nv_wr_d;
  logic [7:0] wbuf [WR_DEPTH];
  logic [WAW-1:0] wwp_q, wwp_d, wrp_q, wrp_d;
  logic [WAW:0] wcnt_q, wcnt_d;
  logic wpush, wpop;
  logic [7:0] rbuf [RD_DEPTH];
  // fill pointer and length carry one extra bit so a full buffer's
  // length cannot wrap to zero
  logic [RAW:0] rfp_q, rfp_d, rlen_q, rlen_d;
  logic [RAW-1:0] ridx_q, ridx_d;
  logic rwe, rte_q, rte_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0] b0_q, b0_d, b1_q, b1_d, nb_q, nb_d, typ_q, typ_d;
  logic done_q, done_d, crc_ok_q, crc_ok_d;
  logic [7:0] rd_byte;

  assign rd_byte = rbuf[ridx_q];
  assign wpop = (wcnt_q != '0) & cmd_ready;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    rw_d = rw_q;
    ack_d = ack_q;
    lock_d = lock_q;
    oe_d = oe_q;
    addr_d = addr_q;
    boot_ld_d = 1'b1;
    nv_wr_d = boot_store;
    wpush = 1'b0;
    ridx_d = ridx_q;
    crc_d = crc_q;
    b0_d = b0_q;
    b1_d = b1_q;
    nb_d = nb_q;
    typ_d = typ_q;
    done_d = 1'b0;
    crc_ok_d = crc_ok_q;
    // power-up address: nonvolatile copy if present, else default
    if (!boot_ld_q && boot_valid) begin
      addr_d = boot_addr;
    end
    if (addr_set) begin
      addr_d = addr_set_val;
    end
    if (start_e || stop_e) begin
      // a write ends at stop or restart; report the packet check
      if ((st_q == isb_pkg::ST_WR_BYTE || st_q == isb_pkg::ST_ACK_W) &&
          nb_q != 8'h00) begin
        done_d = 1'b1;
        crc_ok_d = (nb_q >= isb_pkg::ISB_MIN_PKT) &&
                   ({b0_q, b1_q} == ~crc_q);
      end
      st_d = start_e ? isb_pkg::ST_ADDR : isb_pkg::ST_IDLE;
      bit_d = 3'h0;
      lock_d = 1'b0;
      oe_d = 1'b0;
    end else if (rise_e) begin
      bit_d = bit_q + 3'h1;
      case (st_q)
        isb_pkg::ST_ADDR: begin
          if (bit_q == 3'h7) begin
            rw_d = lnk_sh_q[0];
            st_d = (lnk_sh_q[7:1] == addr_q) ? isb_pkg::ST_ACK_A
                                             : isb_pkg::ST_IGNORE;
          end
        end
        isb_pkg::ST_ACK_A: begin
          bit_d = 3'h0;
          ridx_d = '0;
          if (rw_q == isb_pkg::ISB_DIR_WRITE) begin
            st_d = isb_pkg::ST_WR_BYTE;
            crc_d = isb_pkg::ISB_CRC_INIT;
            nb_d = 8'h00;
          end else begin
            st_d = isb_pkg::ST_RD_BYTE;
          end
        end
        isb_pkg::ST_WR_BYTE: begin
          if (bit_q == 3'h7) begin
            st_d = isb_pkg::ST_ACK_W;
            // occupancy before this cycle's drain decides the fill
            wpush = !lock_q && (wcnt_q < WFULL);
            ack_d = wpush && (wcnt_q + 1'b1 != WFULL);
            lock_d = lock_q | ~ack_d;
            if (wpush) begin
              b0_d = lnk_sh_q;
              b1_d = b0_q;
              if (nb_q == 8'h00) begin
                typ_d = lnk_sh_q;
              end
              if (nb_q != 8'hff) begin
                nb_d = nb_q + 8'h01;
              end
              if (nb_q >= 8'h02) begin
                crc_d = isb_pkg::isb_crc_step(crc_q, b1_q);
              end
            end
          end
        end
        isb_pkg::ST_ACK_W: begin
          st_d = isb_pkg::ST_WR_BYTE;
          bit_d = 3'h0;
        end
        isb_pkg::ST_RD_BYTE: begin
          if (bit_q == 3'h7) begin
            st_d = isb_pkg::ST_ACK_R;
          end
        end
        isb_pkg::ST_ACK_R: begin
          bit_d = 3'h0;
          if (sda_s) begin
            st_d = isb_pkg::ST_IGNORE;
          end else begin
            st_d = isb_pkg::ST_RD_BYTE;
            // past the end the index stays, repeating the final byte
            if (rlen_q != '0 && {1'b0, ridx_q} != rlen_q - 1'b1) begin
              ridx_d = ridx_q + 1'b1;
            end
          end
        end
        default: begin
          bit_d = bit_q;
        end
      endcase
    end else if (fall_e) begin
      case (st_q)
        isb_pkg::ST_ACK_A: oe_d = 1'b1;
        isb_pkg::ST_ACK_W: oe_d = ack_q;
        isb_pkg::ST_RD_BYTE: oe_d = ~rd_byte[3'h7 - bit_q];
        default: oe_d = 1'b0;
      endcase
    end
  end

  // response fill side
  always_comb begin
    rfp_d = rfp_q;
    rlen_d = rlen_q;
    rte_d = rte_q;
    rwe = rsp_valid && (int'(rfp_q) < RD_DEPTH);
    if (rsp_valid) begin
      if (rfp_q == '0) begin
        rte_d = rsp_data[isb_pkg::ISB_CODE_W-1:0] !=
                typ_q[isb_pkg::ISB_CODE_W-1:0];
      end
      if (rsp_last) begin
        rlen_d = rwe ? rfp_q + 1'b1 : rfp_q;
        rfp_d = '0;
      end else if (rwe) begin
        rfp_d = rfp_q + 1'b1;
      end
    end
  end

  // write buffer pointers
  always_comb begin
    wwp_d = wwp_q;
    wrp_d = wrp_q;
    if (wpush) begin
      wwp_d = (wwp_q == WLAST) ? '0 : wwp_q + 1'b1;
    end
    if (wpop) begin
      wrp_d = (wrp_q == WLAST) ? '0 : wrp_q + 1'b1;
    end
    wcnt_d = wcnt_q + {{WAW{1'b0}}, wpush} - {{WAW{1'b0}}, wpop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= isb_pkg::ST_IDLE;
      bit_q <= 3'h0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      lock_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= isb_pkg::ISB_DEF_ADDR;
      boot_ld_q <= 1'b0;
      nv_wr_q <= 1'b0;
      wwp_q <= '0;
      wrp_q <= '0;
      wcnt_q <= '0;
      rfp_q <= '0;
      rlen_q <= '0;
      ridx_q <= '0;
      rte_q <= 1'b0;
      crc_q <= isb_pkg::ISB_CRC_INIT;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      nb_q <= 8'h00;
      typ_q <= 8'h00;
      done_q <= 1'b0;
      crc_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      lock_q <= lock_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      boot_ld_q <= boot_ld_d;
      nv_wr_q <= nv_wr_d;
      wwp_q <= wwp_d;
      wrp_q <= wrp_d;
      wcnt_q <= wcnt_d;
      rfp_q <= rfp_d;
      rlen_q <= rlen_d;
      ridx_q <= ridx_d;
      rte_q <= rte_d;
      crc_q <= crc_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      nb_q <= nb_d;
      typ_q <= typ_d;
      done_q <= done_d;
      crc_ok_q <= crc_ok_d;
    end
  end

  // buffer storage carries no reset; contents are data only
  always_ff @(posedge clk_sys) begin
    if (wpush) begin
      wbuf[wwp_q] <= lnk_sh_q;
    end
    if (rwe) begin
      rbuf[rfp_q[RAW-1:0]] <= rsp_data;
    end
  end

  // ****************************************************
  // address display on held keys
  // ****************************************************
  logic [31:0] key_cnt_q, key_cnt_d;
  logic show_q, show_d;

  always_comb begin
    key_cnt_d = 32'h0;
    show_d = 1'b0;
    if (up_s && dn_s) begin
      key_cnt_d = (key_cnt_q == KEY_HOLD_CYC) ? key_cnt_q
                                              : key_cnt_q + 32'h1;
      show_d = (key_cnt_d == KEY_HOLD_CYC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      key_cnt_q <= 32'h0;
      show_q <= 1'b0;
    end else begin
      key_cnt_q <= key_cnt_d;
      show_q <= show_d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign cmd_valid = (wcnt_q != '0);
  assign cmd_data = wbuf[wrp_q];
  assign cmd_done = done_q;
  assign cmd_info = '{crc_ok: crc_ok_q, cmd_type: typ_q, nbytes: nb_q};
  assign rsp_type_err = rte_q;
  assign nv_wr = nv_wr_q;
  assign nv_addr = addr_q;
  assign show_addr = show_q;
  assign show_addr_val = addr_q;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_reset_addr_default: assert property (
    $rose(rst_b) |-> addr_q == isb_pkg::ISB_DEF_ADDR)
    else $error("address not default after reset");
  a_addr_set_takes: assert property (
    addr_set |=> addr_q == $past(addr_set_val))
    else $error("set address not applied");
  a_ack_own_addr: assert property (
    st_q == isb_pkg::ST_ACK_A && fall_e && !start_e && !stop_e
      |=> sda_oe ##1 sda_oe)
    else $error("own address not acknowledged");
  a_no_drive_ignore: assert property (
    st_q == isb_pkg::ST_IGNORE && $past(st_q) == isb_pkg::ST_IGNORE
      |-> !sda_oe)
    else $error("drove sda while ignoring");
  a_dir_select: assert property (
    st_q == isb_pkg::ST_ACK_A && rise_e && !start_e && !stop_e
      |=> (st_q == isb_pkg::ST_RD_BYTE) == rw_q)
    else $error("direction bit not followed");
  a_nak_on_fill: assert property (
    wpush && wcnt_q + 1'b1 == WFULL |=> !ack_q && lock_q)
    else $error("filling byte not NAKed");
  a_lock_no_store: assert property (
    lock_q |-> !wpush)
    else $error("byte stored after NAK");
  a_lock_stays: assert property (
    lock_q && !start_e && !stop_e |=> lock_q)
    else $error("NAK lock dropped mid transfer");
  a_repeat_last: assert property (
    st_q == isb_pkg::ST_ACK_R && rise_e && rlen_q != '0 &&
      {1'b0, ridx_q} == rlen_q - 1'b1 |=> ridx_q == $past(ridx_q))
    else $error("read index moved past last byte");
  a_show_needs_keys: assert property (
    show_addr |-> $past(up_s) && $past(dn_s) && key_cnt_q == KEY_HOLD_CYC)
    else $error("address shown without held keys");
  a_fifo_bound: assert property (
    wcnt_q <= WFULL)
    else $error("write buffer overflow");
  a_type_match: assert property (
    rsp_valid && rfp_q == '0 && rsp_data[5:0] != typ_q[5:0]
      |=> rsp_type_err)
    else $error("response type mismatch not flagged");

endmodule

// *** bench/isb_host_model.sv ***
// behavioural i2c bus master driving the slave's link pins
`timescale 1ns/10ps
module isb_host_model (
  // link pins
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda
);
  // ****************************************************
  // link timing: phases built from a 30 ns tick
  // ****************************************************
  logic tck;

  // scl phases of 8 ticks keep each phase well above the slave's sync delay
  initial begin
    tck = 1'b0;
    #7;
    forever #15 tck = ~tck;
  end

  // idle bus: scl stands high, sda released to the pull-up
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge tck);
  endtask

  // one scl period; level b placed mid low phase, bus sampled mid high
  task automatic bit_io(input logic b, output logic s);
    ticks(4);
    sda_pull = ~b;
    ticks(4);
    scl_clk = 1'b1;
    ticks(4);
    s = sda;
    ticks(4);
    scl_clk = 1'b0;
  endtask

  // also serves as repeated start
  task automatic send_start();
    ticks(4);
    sda_pull = 1'b0;
    ticks(4);
    scl_clk = 1'b1;
    ticks(8);
    sda_pull = 1'b1;
    ticks(8);
    scl_clk = 1'b0;
  endtask

  task automatic send_stop();
    ticks(4);
    sda_pull = 1'b1;
    ticks(4);
    scl_clk = 1'b1;
    ticks(8);
    sda_pull = 1'b0;
    ticks(8);
  endtask

  // hold stretches scl low for 12 us in mid byte
  task automatic wr_byte(input logic [7:0] b, input logic hold,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      if (hold && i == 3) ticks(400);
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  // last byte gets a nak so the slave sees the read end
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the i2c slave packet buffers
`timescale 1ns/10ps
module tb;
  localparam int WR_D = 8;
  localparam int RD_D = 8;
  localparam int KEY_C = 20;
  logic clk_sys, rst_b, cmd_ready, rsp_valid, rsp_last, addr_set;
  logic boot_valid, boot_store, key_up, key_dn, rsp_type_err, nv_wr;
  logic scl_clk, sda_pull, sda, sda_o, sda_oe, cmd_valid, cmd_done;
  logic show_addr;
  logic [7:0] rsp_data, cmd_data, b8;
  logic [6:0] addr_set_val, boot_addr, nv_addr, show_addr_val, cur, old;
  isb_pkg::isb_done_s cmd_info, info_q;
  int err_count, total_checks, done_cnt, nvwr_cnt, cyc, seed, n0;
  logic [7:0] pkt[$], got[$], rsp[$];
  logic acks[$];

  // open-drain wire with pull-up
  assign sda = ~(sda_oe | sda_pull);

  isb_host_model host (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda));

  isb_i2c_slave #(.WR_DEPTH(WR_D), .RD_DEPTH(RD_D), .KEY_HOLD_CYC(KEY_C)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_done(cmd_done),
    .cmd_info(cmd_info), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_type_err(rsp_type_err), .addr_set(addr_set),
    .addr_set_val(addr_set_val), .boot_valid(boot_valid),
    .boot_addr(boot_addr), .boot_store(boot_store), .nv_wr(nv_wr),
    .nv_addr(nv_addr), .key_up(key_up), .key_dn(key_dn),
    .show_addr(show_addr), .show_addr_val(show_addr_val));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ****************************************************
  // checking helpers
  // ****************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pulses stand one whole cycle, so the falling edge sees them safely
  always @(negedge clk_sys) begin
    cyc++;
    if (cmd_done === 1'b1) begin
      done_cnt++;
      info_q = cmd_info;
    end
    if (nv_wr === 1'b1) nvwr_cnt++;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = isb_pkg::ISB_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, pkt[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ isb_pkg::ISB_CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  // type, length, payload, checksum low byte first
  task automatic make_pkt(input int n);
    logic [15:0] c;
    pkt = {8'($random(seed)) & 8'h3f, 8'(n)};
    repeat (n) pkt.push_back(8'($random(seed)));
    c = ~crc_of(pkt.size());
    pkt.push_back(c[7:0]);
    pkt.push_back(c[15:8]);
  endtask

  task automatic host_wr(input logic [6:0] ad);
    logic k;
    acks = {};
    n0 = done_cnt;
    host.send_start();
    host.wr_byte({ad, 1'b0}, 1'b0, k);
    acks.push_back(k);
    if (k === 1'b0) foreach (pkt[i]) begin
      host.wr_byte(pkt[i], i == 1, k);
      acks.push_back(k);
    end
    host.send_stop();
    repeat (50) if (done_cnt == n0) @(negedge clk_sys);
  endtask

  // foreground drain with random stalls, then the buffer must be empty
  task automatic drain_chk(input int n);
    int k;
    got = {};
    k = 0;
    while (got.size() < n && k < 400) begin
      @(negedge clk_sys);
      k++;
      cmd_ready = $random(seed) & 1;
      if (cmd_ready && cmd_valid === 1'b1) got.push_back(cmd_data);
    end
    @(negedge clk_sys);
    cmd_ready = 1'b0;
    chk_bit("cmd_valid drained", 1'b0, cmd_valid);
    for (int i = 0; i < n; i++) chk_byte("cmd_data", pkt[i], got[i]);
  endtask

  task automatic fill_rsp(input logic [7:0] t, input int n);
    rsp = {t};
    repeat (n - 1) rsp.push_back(8'($random(seed)));
    foreach (rsp[i]) begin
      @(negedge clk_sys);
      rsp_valid = 1'b1;
      rsp_data = rsp[i];
      rsp_last = (i == rsp.size() - 1);
    end
    @(negedge clk_sys);
    rsp_valid = 1'b0;
    rsp_last = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic set_addr(input logic [6:0] a);
    @(negedge clk_sys);
    addr_set = 1'b1;
    addr_set_val = a;
    @(negedge clk_sys);
    addr_set = 1'b0;
    cur = a;
    chk_byte("nv_addr", {1'b0, a}, {1'b0, nv_addr});
    chk_byte("show_addr_val", {1'b0, a}, {1'b0, show_addr_val});
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    seed = 21;
    {rst_b, cmd_ready, rsp_valid, rsp_last, addr_set, boot_valid} = '0;
    {boot_store, key_up, key_dn, rsp_data, addr_set_val, boot_addr} = '0;
    {err_count, total_checks, done_cnt, nvwr_cnt, cyc} = '0;
    cur = 7'h2a;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_byte("reset address", 8'h2a, {1'b0, nv_addr});
    chk_bit("reset cmd_valid", 1'b0, cmd_valid);
    chk_bit("sda_o", 1'b0, sda_o);
    chk_bit("reset sda_oe", 1'b0, sda_oe);
    $display("test reset done");
    // good packet, then one with a broken checksum
    for (int c = 0; c < 2; c++) begin
      make_pkt(2);
      if (c == 1) pkt[5] = pkt[5] ^ 8'h01;
      host_wr(7'h2a);
      foreach (acks[i]) chk_bit("write ack", 1'b0, acks[i]);
      chk_bit("cmd_done", 1'b1, done_cnt == n0 + 1);
      chk_bit("crc_ok", c == 0, info_q.crc_ok);
      chk_byte("nbytes", 8'h06, info_q.nbytes);
      chk_byte("cmd_type", pkt[0], info_q.cmd_type);
      drain_chk(6);
    end
    $display("test packet write done");
    host_wr(7'h2a ^ 7'(1 << ($unsigned($random(seed)) % 7)));
    chk_bit("foreign addr nak", 1'b1, acks[0]);
    chk_bit("foreign no store", 1'b0, cmd_valid);
    $display("test foreign address done");
    // overfill while the foreground stalls
    pkt = {};
    repeat (WR_D + 2) pkt.push_back(8'($random(seed)));
    host_wr(7'h2a);
    for (int i = 1; i < acks.size(); i++)
      chk_bit("fill ack", i >= WR_D, acks[i]);
    drain_chk(WR_D);
    $display("test buffer full done");
    // response fetch past its length, matching and mismatching type
    fill_rsp({2'b01, pkt[0][5:0]}, RD_D);
    chk_bit("rsp_type_err", 1'b0, rsp_type_err);
    repeat (20) @(negedge clk_sys);
    host.send_start();
    host.wr_byte({cur, 1'b1}, 1'b0, acks[0]);
    chk_bit("read addr ack", 1'b0, acks[0]);
    for (int i = 0; i < RD_D + 2; i++) begin
      host.rd_byte(i == RD_D + 1, b8);
      chk_byte("read data", rsp[i < RD_D ? i : RD_D - 1], b8);
    end
    host.send_stop();
    fill_rsp({2'b01, ~pkt[0][5:0]}, 2);
    chk_bit("rsp_type_err", 1'b1, rsp_type_err);
    $display("test read done");
    // boundary and random addresses
    old = cur;
    for (int i = 0; i < 3; i++) begin
      set_addr(i == 0 ? 7'h00 : i == 1 ? 7'h7f : 7'($random(seed)) | 7'h01);
      pkt = {8'($random(seed))};
      host_wr(cur);
      chk_bit("new addr ack", 1'b0, acks[0]);
      chk_bit("short crc_ok", 1'b0, info_q.crc_ok);
      drain_chk(1);
    end
    host_wr(old);
    chk_bit("old addr nak", 1'b1, acks[0]);
    n0 = nvwr_cnt;
    @(negedge clk_sys);
    boot_store = 1'b1;
    @(negedge clk_sys);
    boot_store = 1'b0;
    @(negedge clk_sys);
    chk_bit("nv_wr pulse", 1'b1, nvwr_cnt == n0 + 1);
    chk_byte("nv_addr", {1'b0, cur}, {1'b0, nv_addr});
    $display("test address done");
    key_up = 1'b1;
    key_dn = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk_bit("show early", 1'b0, show_addr);
    repeat (25) @(negedge clk_sys);
    chk_bit("show held", 1'b1, show_addr);
    chk_byte("shown addr", {1'b0, cur}, {1'b0, show_addr_val});
    {key_up, key_dn} = 2'b00;
    $display("test keys done");
    // power cycle with a stored address
    rst_b = 1'b0;
    boot_valid = 1'b1;
    boot_addr = 7'($random(seed));
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    boot_valid = 1'b0;
    chk_byte("boot addr", {1'b0, boot_addr}, {1'b0, nv_addr});
    pkt = {8'h5a};
    host_wr(boot_addr);
    chk_bit("boot addr ack", 1'b0, acks[0]);
    drain_chk(1);
    $display("test boot address done");
    report_and_stop();
  end
endmodule
